// *** core/loop_setpoint_pkg.sv ***
// Constants shared by the loop-current setpoint selector.
package loop_setpoint_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DYN_MAP = 8'h04;
  localparam logic [7:0] OFS_LINK = 8'h08;
  localparam logic [7:0] OFS_LAYOUT = 8'h0C;
  localparam logic [7:0] OFS_URV = 8'h10;
  localparam logic [7:0] OFS_LRV = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1C;
  localparam logic [7:0] OFS_SETPOINT = 8'h20;
  // Device variables read at 0x40..0x54, dynamic ones at 0x60..0x6C.
  localparam logic [2:0] DV_PAGE = 3'h2;
  localparam logic [3:0] DYN_PAGE = 4'h6;
  // Reset values: dynamic slots take device variables 0,1,2,3.
  localparam logic [15:0] DYN_MAP_RST = 16'h3210;
  localparam logic [31:0] LINK_RST = 32'h0000_0001;
  localparam logic [31:0] LAYOUT_RST = 32'h0000_0000;
  localparam logic [31:0] URV_RST = 32'h0000_FFFF;
  localparam logic [31:0] LRV_RST = 32'h0000_0000;
  // Layout register field positions.
  localparam int LAY_INPUT_BIT = 16;
  localparam int LAY_TYPE_LSB = 17;
  localparam int LAY_ORDER_LSB = 19;
  localparam int LAY_DV_LSB = 21;
  // Link register field positions.
  localparam int LINK_BAUD_LSB = 8;
  localparam int LINK_PAR_LSB = 12;
  // Status bit positions.
  localparam int ST_FETCH = 0;
  localparam int ST_SAT_HI = 1;
  localparam int ST_SAT_LO = 2;
  localparam int ST_FAULT = 3;
  // Loop currents in microamps.
  localparam logic [15:0] UA_ZERO = 16'h0FA0;
  localparam logic [15:0] UA_SPAN = 16'h3E80;
  localparam logic [15:0] UA_FULL = 16'h4E20;
  localparam logic [15:0] UA_SAT_HI = 16'h5140;
  localparam logic [15:0] UA_SAT_LO = 16'h0ED8;
  localparam logic [15:0] UA_ALM_HI = 16'h54F6;
  localparam logic [15:0] UA_ALM_LO = 16'h0EA6;
  localparam logic [15:0] UA_FIXED = 16'h0FA0;
  // Shift-subtract divider length and bus responses.
  localparam logic [5:0] DIV_STEPS = 6'h2E;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Setpoint calculation sequencer states.
  typedef enum logic [1:0] {
    CALC_IDLE = 2'b00,
    CALC_DIV = 2'b01,
    CALC_DONE = 2'b10
  } calc_state_type;
endpackage

// *** core/loop_current_setpoint_select.sv ***
// Loop-current setpoint selector with AXI4-Lite registers.
// Functional notes
// - Poll instrument as master, serve data upward.
// - Fetched register lands in device variable 0-5.
// - Any device variable feeds any dynamic slot.
// - Hold link and data layout settings.
// - Primary variable scales onto 4-20 mA.
// - Compare primary variable to limits continuously.
// - Upper limit gives 20.000 mA.
// - Lower limit gives 4.000 mA.
// - Above upper limit gives 20.800 mA.
// - Below lower limit gives 3.800 mA.
// - Fault gives 21.750 or 3.750 mA.
// - Non-zero polling address holds 4.000 mA.
// - Switch off selects high, on selects low.
// - Polling address resets to zero.
`timescale 1ns/1ps
module loop_current_setpoint_select
  import loop_setpoint_pkg::*;
#(
  parameter int NUM_DV = 6
) (
  // Clock and synchronous active-low reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // AXI4-Lite write channels.
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Word fetched by the serial polling engine, and fault flag.
  input wire logic i_fetch_valid,
  input wire logic [31:0] i_fetch_word,
  input wire logic i_fault,
  // Alarm selection switch pin, high when turned on.
  input wire logic i_alarm_level_switch,
  // Settings handed to the serial polling engine.
  output logic [7:0] o_mb_slave_addr,
  output logic [3:0] o_mb_baud_sel,
  output logic [1:0] o_mb_parity,
  output logic [15:0] o_mb_reg_addr,
  output logic o_mb_reg_input,
  output logic [1:0] o_mb_data_type,
  output logic [1:0] o_mb_byte_order,
  // Loop setpoint in microamps and interrupt.
  output logic [15:0] o_setpoint_ua,
  output logic o_irq
);

  // Configuration registers.
  logic [5:0] poll_addr_reg; // Polling (short) address.
  logic [15:0] dyn_map_reg; // Four 4-bit device variable selectors.
  logic [31:0] link_reg; // Slave address, baud select, parity.
  logic [31:0] layout_reg; // Register address, kind, type, order.
  logic [31:0] urv_reg; // Upper range value.
  logic [31:0] lrv_reg; // Lower range value.
  logic [3:0] status_reg; // Sticky event bits.
  logic [3:0] mask_reg; // Interrupt enables.
  logic [31:0] dv_reg [NUM_DV]; // Device variable values.
  logic [31:0] dyn_val [4]; // Dynamic variable values.

  // Bus slave state.
  logic aw_have_reg; // Write address captured.
  logic w_have_reg; // Write data captured.
  logic [7:0] aw_addr_reg; // Captured write address.
  logic [31:0] w_data_reg; // Captured write data.
  logic [3:0] w_strb_reg; // Captured byte enables.
  logic [1:0] bresp_reg; // Write response code.
  logic bvalid_reg; // Write response pending.
  logic rvalid_reg; // Read response pending.
  logic [31:0] rdata_reg; // Read data.
  logic [1:0] rresp_reg; // Read response code.

  // Switch synchroniser and fault edge tracking.
  logic sw_meta_reg; // First flop, read only by sw_reg.
  logic sw_reg; // Synchronised switch level.
  logic fault_d_reg; // Fault delayed for edge detection.

  // Setpoint calculation.
  calc_state_type state_reg; // Sequencer state.
  logic [31:0] snap_pv_reg; // Primary variable snapshot.
  logic snap_hi_reg; // Snapshot is above upper limit.
  logic snap_lo_reg; // Snapshot is below lower limit.
  logic [32:0] rem_reg; // Partial remainder.
  logic [45:0] num_reg; // Dividend, shifted out MSB first.
  logic [31:0] span_reg; // Divisor, upper minus lower limit.
  logic [15:0] quo_reg; // Quotient bits.
  logic [5:0] cnt_reg; // Steps remaining.
  logic [15:0] scaled_reg; // Last in-range or saturated current.
  logic [15:0] setpoint_reg; // Current setpoint.

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Write decode: fires once both channels are held and no answer waits.
  wire do_wr = aw_have_reg && w_have_reg && !bvalid_reg;
  wire [7:0] wa = aw_addr_reg;
  wire wr_ctrl = do_wr && (wa == OFS_CTRL);
  wire wr_dyn = do_wr && (wa == OFS_DYN_MAP);
  wire wr_link = do_wr && (wa == OFS_LINK);
  wire wr_lay = do_wr && (wa == OFS_LAYOUT);
  wire wr_urv = do_wr && (wa == OFS_URV);
  wire wr_lrv = do_wr && (wa == OFS_LRV);
  wire wr_mask = do_wr && (wa == OFS_MASK);
  wire wr_hit = (wa == OFS_CTRL) || (wa == OFS_DYN_MAP) ||
                (wa == OFS_LINK) || (wa == OFS_LAYOUT) ||
                (wa == OFS_URV) || (wa == OFS_LRV) || (wa == OFS_MASK);
  // Selector word after the lane merge; only its low half is stored.
  wire [31:0] dyn_merge = merge({16'h0, dyn_map_reg}, w_data_reg,
                                w_strb_reg);

  // Read decode, with device and dynamic variable pages.
  wire rd_take = i_arvalid && !rvalid_reg;
  wire dv_page = (i_araddr[7:5] == DV_PAGE) &&
                 ({29'h0, i_araddr[4:2]} < NUM_DV);
  wire dyn_page = (i_araddr[7:4] == DYN_PAGE);
  wire rd_status = rd_take && (i_araddr == OFS_STATUS);
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    if (dv_page) begin
      rd_word = dv_reg[i_araddr[4:2]];
    end else if (dyn_page) begin
      rd_word = dyn_val[i_araddr[3:2]];
    end else begin
      case (i_araddr)
        OFS_CTRL: rd_word = {26'h0, poll_addr_reg};
        OFS_DYN_MAP: rd_word = {16'h0, dyn_map_reg};
        OFS_LINK: rd_word = link_reg;
        OFS_LAYOUT: rd_word = layout_reg;
        OFS_URV: rd_word = urv_reg;
        OFS_LRV: rd_word = lrv_reg;
        OFS_STATUS: rd_word = {28'h0, status_reg};
        OFS_MASK: rd_word = {28'h0, mask_reg};
        OFS_SETPOINT: rd_word = {16'h0, setpoint_reg};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // Fetched word reordered and sized per the data layout.
  wire [1:0] lay_type = layout_reg[LAY_TYPE_LSB +: 2];
  wire [1:0] lay_order = layout_reg[LAY_ORDER_LSB +: 2];
  wire [2:0] lay_dv = layout_reg[LAY_DV_LSB +: 3];
  logic [31:0] fetch_ord;
  always_comb begin
    case (lay_order)
      2'h1: fetch_ord = {i_fetch_word[15:0], i_fetch_word[31:16]};
      2'h2: fetch_ord = {i_fetch_word[23:16], i_fetch_word[31:24],
                         i_fetch_word[7:0], i_fetch_word[15:8]};
      2'h3: fetch_ord = {i_fetch_word[7:0], i_fetch_word[15:8],
                         i_fetch_word[23:16], i_fetch_word[31:24]};
      default: fetch_ord = i_fetch_word;
    endcase
  end
  wire [31:0] fetch_val = (lay_type == 2'h0) ?
                          {16'h0, fetch_ord[15:0]} : fetch_ord;

  // Device variables, each loaded when the target index names it.
  genvar g;
  generate
    for (g = 0; g < NUM_DV; g++) begin : g_dv
      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
          dv_reg[g] <= 32'h0000_0000;
        end else if (i_fetch_valid && ({29'h0, lay_dv} == g)) begin
          dv_reg[g] <= fetch_val;
        end
      end
    end
    for (g = 0; g < 4; g++) begin : g_dyn
      wire [3:0] sel = dyn_map_reg[4*g +: 4];
      assign dyn_val[g] = ({28'h0, sel} < NUM_DV) ?
                          dv_reg[sel[2:0]] : 32'h0000_0000;
    end
  endgenerate

  // Primary variable and settings toward the polling engine.
  wire [31:0] pv = dyn_val[0];
  assign o_mb_slave_addr = link_reg[7:0];
  assign o_mb_baud_sel = link_reg[LINK_BAUD_LSB +: 4];
  assign o_mb_parity = link_reg[LINK_PAR_LSB +: 2];
  assign o_mb_reg_addr = layout_reg[15:0];
  assign o_mb_reg_input = layout_reg[LAY_INPUT_BIT];
  assign o_mb_data_type = lay_type;
  assign o_mb_byte_order = lay_order;

  // Configuration register writes.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      poll_addr_reg <= 6'h00;
      dyn_map_reg <= DYN_MAP_RST;
      link_reg <= LINK_RST;
      layout_reg <= LAYOUT_RST;
      urv_reg <= URV_RST;
      lrv_reg <= LRV_RST;
      mask_reg <= 4'h0;
    end else begin
      if (wr_ctrl) poll_addr_reg <= w_data_reg[5:0] & {6{w_strb_reg[0]}}
                                    | poll_addr_reg & {6{!w_strb_reg[0]}};
      if (wr_dyn) dyn_map_reg <= dyn_merge[15:0];
      if (wr_link) link_reg <= merge(link_reg, w_data_reg, w_strb_reg);
      if (wr_lay) layout_reg <= merge(layout_reg, w_data_reg, w_strb_reg);
      if (wr_urv) urv_reg <= merge(urv_reg, w_data_reg, w_strb_reg);
      if (wr_lrv) lrv_reg <= merge(lrv_reg, w_data_reg, w_strb_reg);
      if (wr_mask) mask_reg <= w_data_reg[3:0] & {4{w_strb_reg[0]}}
                               | mask_reg & {4{!w_strb_reg[0]}};
    end
  end

  // Write channel capture and response.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (i_awvalid && !aw_have_reg) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && !w_have_reg) begin
        w_have_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (do_wr) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && i_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign o_awready = !aw_have_reg;
  assign o_wready = !w_have_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;

  // Read channel: one outstanding read, answered the next cycle.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign o_arready = !rvalid_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;

  // Switch pin synchroniser and fault edge register.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sw_meta_reg <= 1'b0;
      sw_reg <= 1'b0;
      fault_d_reg <= 1'b0;
    end else begin
      sw_meta_reg <= i_alarm_level_switch;
      sw_reg <= sw_meta_reg;
      fault_d_reg <= i_fault;
    end
  end

  // Sticky events; a new event wins over the clearing read.
  wire calc_end = (state_reg == CALC_DONE);
  wire [3:0] ev = {i_fault && !fault_d_reg, calc_end && snap_lo_reg,
                   calc_end && snap_hi_reg, i_fetch_valid};
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      status_reg <= 4'h0;
    end else begin
      status_reg <= (rd_status ? 4'h0 : status_reg) | ev;
    end
  end
  assign o_irq = |(status_reg & mask_reg);

  // Sequencer: snapshot, divide, publish, repeat.
  wire [31:0] span = urv_reg - lrv_reg;
  wire [32:0] trial = {rem_reg[31:0], num_reg[45]};
  wire fits = trial >= {1'b0, span_reg};
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_reg <= CALC_IDLE;
      snap_pv_reg <= 32'h0000_0000;
      snap_hi_reg <= 1'b0;
      snap_lo_reg <= 1'b0;
      rem_reg <= 33'h0_0000_0000;
      num_reg <= 46'h0000_0000_0000;
      span_reg <= 32'h0000_0000;
      quo_reg <= 16'h0000;
      cnt_reg <= 6'h00;
      scaled_reg <= UA_ZERO;
    end else begin
      case (state_reg)
        CALC_IDLE: begin
          snap_pv_reg <= pv;
          snap_hi_reg <= pv > urv_reg;
          snap_lo_reg <= pv < lrv_reg;
          span_reg <= span;
          num_reg <= 46'((pv - lrv_reg) * 46'(UA_SPAN));
          rem_reg <= 33'h0_0000_0000;
          quo_reg <= 16'h0000;
          cnt_reg <= DIV_STEPS;
          state_reg <= CALC_DIV;
        end
        CALC_DIV: begin
          num_reg <= {num_reg[44:0], 1'b0};
          rem_reg <= fits ? trial - {1'b0, span_reg} : trial;
          quo_reg <= {quo_reg[14:0], fits};
          cnt_reg <= cnt_reg - 6'h01;
          if (cnt_reg == 6'h01 || span_reg == 32'h0000_0000) begin
            state_reg <= CALC_DONE;
          end
        end
        CALC_DONE: begin
          if (snap_hi_reg) begin
            scaled_reg <= UA_SAT_HI;
          end else if (snap_lo_reg) begin
            scaled_reg <= UA_SAT_LO;
          end else if (span_reg == 32'h0000_0000) begin
            scaled_reg <= UA_FULL;
          end else begin
            scaled_reg <= UA_ZERO + quo_reg;
          end
          state_reg <= CALC_IDLE;
        end
        default: state_reg <= CALC_IDLE;
      endcase
    end
  end

  // Output choice: fault alarm, fixed address current, then scaled.
  wire [15:0] alarm_ua = sw_reg ? UA_ALM_LO : UA_ALM_HI;
  wire [15:0] setpoint_next = i_fault ? alarm_ua :
                              (poll_addr_reg != 6'h00) ? UA_FIXED :
                              scaled_reg;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      setpoint_reg <= UA_FIXED;
    end else begin
      setpoint_reg <= setpoint_next;
    end
  end
  assign o_setpoint_ua = setpoint_reg;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  property p_alarm_hi;
    i_fault && !sw_reg |=> o_setpoint_ua == 16'h54F6;
  endproperty
  a_alarm_hi: assert property (p_alarm_hi)
    else $error("high alarm current not driven");

  property p_alarm_lo;
    i_fault && sw_reg |=> o_setpoint_ua == 16'h0EA6;
  endproperty
  a_alarm_lo: assert property (p_alarm_lo)
    else $error("low alarm current not driven");

  property p_fixed_addr;
    !i_fault && poll_addr_reg != 6'h00 |=> o_setpoint_ua == 16'h0FA0;
  endproperty
  a_fixed_addr: assert property (p_fixed_addr)
    else $error("non-zero address did not hold 4 mA");

  property p_sat_hi;
    calc_end && snap_hi_reg ##1 (!i_fault && poll_addr_reg == 6'h00)
      |=> o_setpoint_ua == 16'h5140;
  endproperty
  a_sat_hi: assert property (p_sat_hi)
    else $error("upper saturation current wrong");

  property p_sat_lo;
    calc_end && snap_lo_reg && !snap_hi_reg ##1
      (!i_fault && poll_addr_reg == 6'h00) |=> o_setpoint_ua == 16'h0ED8;
  endproperty
  a_sat_lo: assert property (p_sat_lo)
    else $error("lower saturation current wrong");

  property p_top;
    calc_end && !snap_hi_reg && !snap_lo_reg && snap_pv_reg == urv_reg &&
      $stable(urv_reg) |=> scaled_reg == 16'h4E20;
  endproperty
  a_top: assert property (p_top)
    else $error("upper limit did not give 20 mA");

  property p_scaled_span;
    calc_end && !snap_hi_reg && !snap_lo_reg
      |=> scaled_reg >= 16'h0FA0 && scaled_reg <= 16'h4E20;
  endproperty
  a_scaled_span: assert property (p_scaled_span)
    else $error("scaled current outside 4-20 mA");

  property p_poll_reset;
    $rose(i_rst_n) |-> poll_addr_reg == 6'h00;
  endproperty
  a_poll_reset: assert property (p_poll_reset)
    else $error("polling address not zero after reset");

  property p_rerun;
    calc_end |=> state_reg == CALC_IDLE ##1 state_reg == CALC_DIV;
  endproperty
  a_rerun: assert property (p_rerun)
    else $error("limit comparison did not repeat");

endmodule // loop_current_setpoint_select

// *** verif/fetch_source_model.sv ***
// Behavioural model of the instrument side that feeds fetched words.
`timescale 1ns/1ps
module fetch_source_model (
  // Clock of the block.
  input wire logic i_ref_clk,
  // Fetched word strobe, word and fault flag.
  output logic o_fetch_valid,
  output logic [31:0] o_fetch_word,
  output logic o_fault
);
  // Quiet at start: no word offered, no fault, data line scrambled.
  initial begin
    o_fetch_valid = 1'b0;
    o_fetch_word = 32'hA5A5_5A5A;
    o_fault = 1'b0;
  end
  // Offers one polled word for one cycle, then inverts the line so a
  // late sample can never see the old word. Call at a rising edge.
  task automatic send(input logic [31:0] w);
    o_fetch_word <= w;
    o_fetch_valid <= 1'b1;
    @(posedge i_ref_clk);
    o_fetch_valid <= 1'b0;
    o_fetch_word <= ~w;
  endtask
  // Raises or drops the fault flag at the calling edge.
  task automatic set_fault(input logic f);
    o_fault <= f;
  endtask
endmodule // fetch_source_model

// *** verif/tb.sv ***
// Self-checking bench for the loop-current setpoint selector.
`timescale 1ns/1ps
module tb;
  import loop_setpoint_pkg::*;
  // Clock, reset, switch and bus master signals.
  logic clk;
  logic rst_n = 1'b0;
  logic sw = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  // Outputs of the block and of the instrument model.
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0] o_bresp, o_rresp, o_mb_parity, o_mb_data_type;
  logic [1:0] o_mb_byte_order;
  logic [31:0] o_rdata, fword;
  logic [7:0] o_mb_slave_addr;
  logic [3:0] o_mb_baud_sel;
  logic [15:0] o_mb_reg_addr, o_setpoint_ua;
  logic o_mb_reg_input, fvalid, fault;
  // Counters of comparisons and mismatches.
  int tests_run = 0;
  int n_mismatch = 0;

  // Instrument model on the far side.
  fetch_source_model src (.i_ref_clk(clk), .o_fetch_valid(fvalid),
    .o_fetch_word(fword), .o_fault(fault));

  // Block under test.
  loop_current_setpoint_select #(.NUM_DV(6)) uut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(rready), .i_fetch_valid(fvalid), .i_fetch_word(fword),
    .i_fault(fault), .i_alarm_level_switch(sw),
    .o_mb_slave_addr(o_mb_slave_addr), .o_mb_baud_sel(o_mb_baud_sel),
    .o_mb_parity(o_mb_parity), .o_mb_reg_addr(o_mb_reg_addr),
    .o_mb_reg_input(o_mb_reg_input), .o_mb_data_type(o_mb_data_type),
    .o_mb_byte_order(o_mb_byte_order), .o_setpoint_ua(o_setpoint_ua),
    .o_irq(o_irq));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time,
               msg, seen, exp);
    end
  endtask

  // One write; readies are looked at before the edge that takes them.
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic ra, rw, rb;
    logic [1:0] resp;
    rb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !rb; n++) begin
      @(negedge clk);
      ra = o_awready;
      rw = o_wready;
      rb = o_bvalid;
      resp = o_bresp;
      @(posedge clk);
      if (ra) awvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
      if (rb) bready <= 1'b0;
    end
    // A write that is never answered must not pass on a stale response.
    if (!rb) resp = 2'h3;
    chk(32'(resp), 32'(er), "write response");
    // One idle edge keeps the next request off the release step.
    @(posedge clk);
  endtask

  // One read; data and response are taken with rvalid.
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ra, rv;
    rv = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !rv; n++) begin
      @(negedge clk);
      ra = o_arready;
      rv = o_rvalid;
      d = o_rdata;
      r = o_rresp;
      @(posedge clk);
      if (ra) arvalid <= 1'b0;
      if (rv) rready <= 1'b0;
    end
    // A read that is never answered reports a response no slave gives.
    if (!rv) r = 2'h3;
    // One idle edge keeps the next request off the release step.
    @(posedge clk);
  endtask

  // Reads a register and compares data and an OKAY response.
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string msg);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, e, msg);
    chk(32'(r), 32'(RESP_OKAY), "read response");
  endtask

  // Waits for the setpoint to settle, bounded, then compares it.
  task automatic sp(input logic [15:0] e);
    for (int n = 0; n < 300 && o_setpoint_ua !== e; n++) @(negedge clk);
    chk(32'(o_setpoint_ua), 32'(e), "setpoint");
    @(posedge clk);
  endtask

  // Sets the range, feeds a primary value and checks the current.
  task automatic scale(input logic [31:0] u, input logic [31:0] l,
                       input logic [31:0] p, input logic [15:0] e);
    axw(OFS_URV, u, RESP_OKAY);
    axw(OFS_LRV, l, RESP_OKAY);
    src.send(p);
    sp(e);
  endtask

  // Reset values of outputs and settings.
  task automatic t_reset();
    chk(32'(o_setpoint_ua), 32'h0000_0FA0, "reset current");
    chk(32'(o_mb_slave_addr), 32'h0000_0001, "slave address");
    rdc(OFS_CTRL, 32'h0000_0000, "poll address");
    rdc(OFS_DYN_MAP, 32'h0000_3210, "map");
    rdc(OFS_LINK, 32'h0000_0001, "link");
  endtask

  // Scaling, range ends and saturation, with an offset lower limit.
  task automatic t_scale();
    scale(32'h3E8, 32'h0, 32'h1F4, 16'h2EE0);
    scale(32'h3E8, 32'h0, 32'h3E8, 16'h4E20);
    scale(32'h3E8, 32'h0, 32'h0, 16'h0FA0);
    scale(32'h3E8, 32'h0, 32'h3E9, 16'h5140);
    scale(32'h44C, 32'h64, 32'h32, 16'h0ED8);
    scale(32'h44C, 32'h64, 32'h15E, 16'h1F40);
  endtask

  // Alarm currents by switch, then priority against the address.
  task automatic t_fault();
    src.set_fault(1'b1);
    sp(16'h54F6);
    sw <= 1'b1;
    sp(16'h0EA6);
    axw(OFS_CTRL, 32'h0000_0005, RESP_OKAY);
    repeat (4) @(posedge clk);
    chk(32'(o_setpoint_ua), 32'h0000_0EA6, "alarm first");
    src.set_fault(1'b0);
    sp(16'h0FA0);
    src.send(32'h44D);
    repeat (120) @(posedge clk);
    chk(32'(o_setpoint_ua), 32'h0000_0FA0, "address first");
    axw(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    sp(16'h5140);
  endtask

  // Fetch event raises, read clears, mask blocks the interrupt.
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] r;
    axw(OFS_MASK, 32'h0000_0001, RESP_OKAY);
    axr(OFS_STATUS, d, r);
    src.send(32'h200);
    repeat (2) @(negedge clk);
    chk(32'(o_irq), 32'h1, "irq raised");
    @(posedge clk);
    axr(OFS_STATUS, d, r);
    chk(d & 32'h1, 32'h1, "fetch status");
    @(negedge clk);
    chk(32'(o_irq), 32'h0, "irq cleared");
    @(posedge clk);
    axw(OFS_MASK, 32'h0000_0000, RESP_OKAY);
    src.send(32'h201);
    repeat (2) @(negedge clk);
    chk(32'(o_irq), 32'h0, "irq masked");
    @(posedge clk);
  endtask

  // Link and layout settings, byte order, mapping and bus errors.
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axw(OFS_LINK, 32'h0000_2305, RESP_OKAY);
    axw(OFS_LAYOUT, 32'h007B_7530, RESP_OKAY);
    axw(OFS_DYN_MAP, 32'h0000_0123, RESP_OKAY);
    chk(32'({o_mb_parity, o_mb_baud_sel, o_mb_slave_addr}),
        32'h0000_2305, "link outputs");
    chk(32'({o_mb_byte_order, o_mb_data_type, o_mb_reg_input,
        o_mb_reg_addr}), 32'h001B_7530, "layout outputs");
    src.send(32'h1122_3344);
    rdc(8'h4C, 32'h4433_2211, "device variable 3");
    rdc(8'h60, 32'h4433_2211, "primary variable");
    axr(8'h30, d, r);
    chk(d, 32'h0, "unmapped data");
    chk(32'(r), 32'(RESP_SLVERR), "unmapped response");
    axw(OFS_SETPOINT, 32'h0, RESP_SLVERR);
    // Only byte lane 0 may change the polling address.
    wstrb <= 4'h2;
    axw(OFS_CTRL, 32'h0000_0007, RESP_OKAY);
    wstrb <= 4'hF;
    rdc(OFS_CTRL, 32'h0000_0000, "lane 1 write");
    axw(OFS_CTRL, 32'h0000_0007, RESP_OKAY);
    rdc(OFS_CTRL, 32'h0000_0007, "poll address");
    // A mid-run reset must bring the polling address back to zero.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk(32'(o_setpoint_ua), 32'h0000_0FA0, "reset current");
    rdc(OFS_CTRL, 32'h0000_0000, "poll address after reset");
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short long after the tests should have ended.
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence: two reset cycles, then every scenario.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_scale();
    t_fault();
    t_irq();
    t_regs();
    end_of_test();
  end
endmodule // tb
